// >>> design/ltp_target_port.sv
// serial target port: address match, pointer, write buffer and reads
//
// How it works
// - answer address with top bits 100, low four bits from straps
// - last address bit: 0 means controller writes, 1 means it reads
// - strap tied to ground/scl/sda/supply gives 00/01/10/11; low strap bits 1:0
// - data sampled on scl high; we change sda only while scl is low
// - sda falling while scl high is a start; then compare address byte
// - on address match we pull sda low for the ninth clock
// - byte after a write address loads the register pointer, acknowledged
// - each following data byte is acknowledged and stored at the pointer
// - sda rising while scl high is a stop; transfer ends there
// - pointer advances by one during each data byte acknowledge
// - auto increment continues for any number of bytes
// - any register can be read back through the port
// - after read address acknowledge, selected register shifts out msb first
`timescale 1ns/10ps
module ltp_target_port
	import ltp_pkg::*;
#(
	parameter int FIFO_DEPTH_P = ltp_pkg::FIFO_DEPTH
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      scl_i,
	output      logic                      scl_o,
	output      logic                      scl_oe,
	input  wire logic                      sda_i,
	output      logic                      sda_o,
	output      logic                      sda_oe,
	input  wire logic                      addr_strap_low,
	input  wire logic                      addr_strap_high,
	output      logic [ltp_pkg::PTR_W-1:0] reg_addr,
	input  wire logic [ltp_pkg::BYTE_BITS-1:0] reg_rd_data,
	output      logic [ltp_pkg::PTR_W-1:0] reg_wr_addr,
	output      logic [ltp_pkg::BYTE_BITS-1:0] reg_wr_data,
	output      logic                      reg_wr_valid,
	input  wire logic                      reg_wr_ready
);
	import ltp_pkg::*;

	generate
		if (FIFO_DEPTH_P < 2) begin : g_bad_depth
			$error("ltp_target_port needs a write buffer of at least 2 words");
		end
	endgenerate

	ltp_state_t     state_r;
	logic [3:0]     cnt_r;
	logic [7:0]     shreg_r;
	logic           dir_r;
	logic           ack_r;
	logic [PTR_W-1:0] ptr_r;
	logic           scl_q_r;
	logic           sda_q_r;
	logic           sda_oe_r;
	logic           scl_oe_r;
	logic           pin_low_r;
	logic [1:0]     strap_q_r;
	logic [1:0]     strap_s_r;
	logic [1:0]     strap_i_r;
	logic           strap_wait_r;
	logic [1:0]     low_code_r;
	logic [1:0]     high_code_r;
	logic [6:0]     own_addr;
	logic           scl_rise;
	logic           scl_fall;
	logic           start;
	logic           stop;
	logic           rx_state;
	logic           byte_end;
	logic           addr_hit;
	logic           w_push;
	logic           r_load;

	ltp_stream_if #(.W(WR_W)) wr_s ();

	// ------------------------------------------------------------
	// bus conditions
	// ------------------------------------------------------------
	assign scl_rise = scl_i && !scl_q_r;
	assign scl_fall = !scl_i && scl_q_r;
	assign start    = scl_i && scl_q_r && sda_q_r && !sda_i;
	assign stop     = scl_i && scl_q_r && !sda_q_r && sda_i;
	assign rx_state = (state_r == ST_ADDR) || (state_r == ST_PTR)
		|| (state_r == ST_WDATA);
	assign byte_end = rx_state && scl_fall && (cnt_r == CNT_FULL);
	assign own_addr = {ADDR_FIXED, high_code_r, low_code_r};
	assign addr_hit = (shreg_r[7:1] == own_addr);
	assign w_push   = (state_r == ST_WPUSH) && wr_s.in_ready;
	assign r_load   = (state_r == ST_RLOAD) && wr_s.empty;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
		end
	end

	// ------------------------------------------------------------
	// strap decode
	// ------------------------------------------------------------
	function automatic logic [1:0] strap_decode(input logic at_start,
		input logic before_start, input logic at_fall);
		if (!at_start) begin
			strap_decode = before_start ? STRAP_SDA : STRAP_GND;
		end else begin
			strap_decode = at_fall ? STRAP_VCC : STRAP_SCL;
		end
	endfunction : strap_decode

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_q_r    <= 2'h0;
			strap_s_r    <= 2'h0;
			strap_i_r    <= 2'h0;
			strap_wait_r <= 1'b0;
			low_code_r   <= STRAP_GND;
			high_code_r  <= STRAP_GND;
		end else begin
			strap_q_r <= {addr_strap_high, addr_strap_low};
			if (start) begin
				strap_s_r    <= {addr_strap_high, addr_strap_low};
				strap_i_r    <= strap_q_r;
				strap_wait_r <= 1'b1;
			end else if (scl_fall && strap_wait_r) begin
				strap_wait_r <= 1'b0;
				low_code_r   <= strap_decode(strap_s_r[0], strap_i_r[0],
					addr_strap_low);
				high_code_r  <= strap_decode(strap_s_r[1], strap_i_r[1],
					addr_strap_high);
			end
		end
	end

	// ------------------------------------------------------------
	// byte sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			shreg_r <= 8'h00;
			dir_r   <= 1'b0;
			ack_r   <= 1'b0;
		end else if (start) begin
			state_r <= ST_ADDR;
			cnt_r   <= 4'h0;
		end else if (stop) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise && cnt_r != CNT_FULL) begin
						shreg_r <= {shreg_r[6:0], sda_i};
						cnt_r   <= 4'(cnt_r + 4'h1);
					end
					if (byte_end) begin
						cnt_r <= 4'h0;
						case (state_r)
							ST_ADDR: begin
								state_r <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
								dir_r   <= shreg_r[DIR_POS];
							end
							ST_PTR:  state_r <= ST_PTR_ACK;
							default: state_r <= ST_WPUSH;
						endcase
					end
				end
				ST_WPUSH: begin
					if (w_push) begin
						state_r <= ST_WDATA_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						state_r <= dir_r ? ST_RLOAD : ST_PTR;
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						state_r <= ST_WDATA;
					end
				end
				ST_RLOAD: begin
					if (r_load) begin
						shreg_r <= reg_rd_data;
						cnt_r   <= 4'h0;
						state_r <= ST_RDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (cnt_r == CNT_LAST_TX) begin
							cnt_r   <= 4'h0;
							state_r <= ST_RDATA_ACK;
						end else begin
							cnt_r   <= 4'(cnt_r + 4'h1);
							shreg_r <= {shreg_r[6:0], 1'b1};
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						ack_r <= !sda_i;
					end
					if (scl_fall) begin
						state_r <= ack_r ? ST_RLOAD : ST_IGNORE;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					state_r <= state_r;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// register pointer
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_r <= PTR_RESET;
		end else if ((state_r == ST_PTR) && byte_end && !start && !stop) begin
			ptr_r <= shreg_r;
		end else if (w_push || r_load) begin
			ptr_r <= PTR_W'(ptr_r + PTR_STEP);
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end else if (start || stop) begin
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end else begin
			case (state_r)
				ST_ADDR: begin
					if (byte_end && addr_hit) begin
						sda_oe_r <= 1'b1;
					end
				end
				ST_PTR: begin
					if (byte_end) begin
						sda_oe_r <= 1'b1;
					end
				end
				ST_WDATA: begin
					if (byte_end) begin
						scl_oe_r <= 1'b1;
					end
				end
				ST_WPUSH: begin
					if (w_push) begin
						sda_oe_r <= 1'b1;
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe_r <= 1'b0;
						scl_oe_r <= (state_r == ST_ADDR_ACK) && dir_r;
					end else begin
						scl_oe_r <= 1'b0;
					end
				end
				ST_RLOAD: begin
					if (r_load) begin
						sda_oe_r <= !reg_rd_data[7];
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						sda_oe_r <= (cnt_r == CNT_LAST_TX) ? 1'b0 : !shreg_r[6];
					end else begin
						scl_oe_r <= 1'b0;
					end
				end
				ST_RDATA_ACK: begin
					if (scl_fall) begin
						scl_oe_r <= ack_r;
					end
				end
				default: begin
					sda_oe_r <= 1'b0;
					scl_oe_r <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_low_r <= 1'b0;
		end else begin
			pin_low_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// write buffer
	// ------------------------------------------------------------
	assign wr_s.in_valid  = (state_r == ST_WPUSH);
	assign wr_s.in_data   = {ptr_r, shreg_r};
	assign wr_s.out_ready = reg_wr_ready;

	ltp_fifo #(
		.W     (WR_W),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo (
		.clk (clk),
		.rst (rst),
		.s   (wr_s.fifo)
	);

	assign scl_o        = pin_low_r;
	assign sda_o        = pin_low_r;
	assign scl_oe       = scl_oe_r;
	assign sda_oe       = sda_oe_r;
	assign reg_addr     = ptr_r;
	assign reg_wr_valid = wr_s.out_valid;
	assign reg_wr_addr  = wr_s.out_data[WR_W-1:BYTE_BITS];
	assign reg_wr_data  = wr_s.out_data[BYTE_BITS-1:0];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_START_TO_ADDR: assert property (
		start |=> (state_r == ST_ADDR) && (cnt_r == 4'h0)
	) else $error("start did not restart address reception");

	AST_STOP_ENDS: assert property (
		stop |=> (state_r == ST_IDLE) && !sda_oe_r && !scl_oe_r
	) else $error("stop did not end the transfer");

	AST_ADDR_ACK: assert property (
		(state_r == ST_ADDR) && byte_end && addr_hit && !start && !stop
		|=> sda_oe_r && (state_r == ST_ADDR_ACK)
	) else $error("matching address not acknowledged");

	AST_MISS_RELEASED: assert property (
		(state_r == ST_ADDR) && byte_end && !addr_hit && !start && !stop
		|=> !sda_oe_r [*2] ##0 (state_r == ST_IGNORE)
	) else $error("foreign address touched sda");

	AST_PTR_LOAD: assert property (
		(state_r == ST_PTR) && byte_end && !start && !stop
		|=> (reg_addr == $past(shreg_r)) && sda_oe_r
	) else $error("pointer byte not loaded and acknowledged");

	AST_PTR_STEP: assert property (
		w_push && !start && !stop |=> (ptr_r == PTR_W'($past(ptr_r) + PTR_STEP))
	) else $error("pointer did not advance on write acknowledge");

	AST_READ_MSB: assert property (
		r_load |=> (sda_oe_r == !$past(reg_rd_data[7])) && (state_r == ST_RDATA)
	) else $error("read byte did not start with its top bit");

	AST_SDA_LOW_PHASE: assert property (
		$rose(sda_oe_r) |-> !scl_i
	) else $error("sda driven while scl high");

	AST_NACK_STOPS_READ: assert property (
		(state_r == ST_RDATA_ACK) && scl_fall && !ack_r && !start && !stop
		|=> (state_r == ST_IGNORE) && !sda_oe_r
	) else $error("read continued after not-acknowledge");

endmodule : ltp_target_port

// >>> design/ltp_pkg.sv
// constants and types shared by the led driver serial target port
package ltp_pkg;

	// ------------------------------------------------------------
	// address byte layout
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_FIXED    = 3'h4;
	localparam int         BYTE_BITS     = 8;
	localparam int         PTR_W         = 8;
	localparam logic [3:0] CNT_FULL      = 4'h8;
	localparam logic [3:0] CNT_LAST_TX   = 4'h7;
	localparam int         DIR_POS       = 0;

	// ------------------------------------------------------------
	// strap decode codes
	// ------------------------------------------------------------
	localparam logic [1:0] STRAP_GND     = 2'h0;
	localparam logic [1:0] STRAP_SCL     = 2'h1;
	localparam logic [1:0] STRAP_SDA     = 2'h2;
	localparam logic [1:0] STRAP_VCC     = 2'h3;

	// ------------------------------------------------------------
	// write buffer and reset values
	// ------------------------------------------------------------
	localparam int         FIFO_DEPTH    = 4;
	localparam int         WR_W          = PTR_W + BYTE_BITS;
	localparam logic [7:0] PTR_RESET     = 8'h00;
	localparam logic [7:0] PTR_STEP      = 8'h01;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WPUSH,
		ST_WDATA_ACK,
		ST_RLOAD,
		ST_RDATA,
		ST_RDATA_ACK,
		ST_IGNORE
	} ltp_state_t;

endpackage : ltp_pkg

// >>> design/ltp_stream_if.sv
// valid/ready carrier between the port logic and its write buffer
`timescale 1ns/10ps
interface ltp_stream_if #(
	parameter int W = 16
);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	logic         empty;

	modport fifo (
		input  in_valid,
		input  in_data,
		input  out_ready,
		output in_ready,
		output out_valid,
		output out_data,
		output empty
	);

	modport user (
		output in_valid,
		output in_data,
		output out_ready,
		input  in_ready,
		input  out_valid,
		input  out_data,
		input  empty
	);
endinterface : ltp_stream_if

// >>> design/ltp_fifo.sv
// small write buffer with a registered head word
`timescale 1ns/10ps
module ltp_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	ltp_stream_if.fifo s
);
	import ltp_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("ltp_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic          out_valid_r;
	logic [W-1:0]  out_data_r;
	logic          push;
	logic          pop;

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	assign s.in_ready  = (count_r != CW'(DEPTH));
	assign push        = s.in_valid && s.in_ready;
	assign pop         = (count_r != '0) && (!out_valid_r || s.out_ready);
	assign s.out_valid = out_valid_r;
	assign s.out_data  = out_data_r;
	assign s.empty     = (count_r == '0) && !out_valid_r;

	// ------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= s.in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			end
			if (pop) begin
				rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
			end
			if (push && !pop) begin
				count_r <= CW'(count_r + 1'b1);
			end else if (pop && !push) begin
				count_r <= CW'(count_r - 1'b1);
			end
		end
	end

	// ------------------------------------------------------------
	// head register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_data_r  <= '0;
		end else if (pop) begin
			out_valid_r <= 1'b1;
			out_data_r  <= mem[rd_ptr_r];
		end else if (s.out_ready) begin
			out_valid_r <= 1'b0;
		end
	end

endmodule : ltp_fifo

// >>> testbench/ltp_i2c_ctrl_model.sv
// bus controller model: drives scl and sda through open-drain releases
`timescale 1ns/10ps
module ltp_i2c_ctrl_model #(
	parameter int HALF = 5
) (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output      logic scl_m,
	output      logic sda_m,
	output      logic hung
);
	// ------------------------------------------------------------
	// idle lines released
	// ------------------------------------------------------------
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		hung  = 1'b0;
	end

	// ------------------------------------------------------------
	// bit level
	// ------------------------------------------------------------
	task automatic gap();
		repeat (HALF) @(posedge clk);
	endtask : gap

	// raise scl, wait out a stretch, hold the high phase
	task automatic rise();
		int n;
		n = 0;
		scl_m <= 1'b1;
		@(posedge clk);
		while (scl !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) hung <= 1'b1;
		gap();
	endtask : rise

	// sda changes only while scl is low
	task automatic xfer_bit(input logic b, output logic r);
		sda_m <= b;
		gap();
		rise();
		r = sda;
		scl_m <= 1'b0;
		@(posedge clk);
	endtask : xfer_bit

	// ------------------------------------------------------------
	// frame level
	// ------------------------------------------------------------
	task automatic start();
		sda_m <= 1'b1;
		gap();
		rise();
		sda_m <= 1'b0;
		gap();
		scl_m <= 1'b0;
		@(posedge clk);
	endtask : start

	task automatic stop();
		sda_m <= 1'b0;
		gap();
		rise();
		sda_m <= 1'b1;
		gap();
	endtask : stop

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
		xfer_bit(1'b1, r);
		ack = !r;
	endtask : wbyte

	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
		xfer_bit(!more, r);
	endtask : rbyte
endmodule : ltp_i2c_ctrl_model

// >>> testbench/ltp_target_port_tb_top.sv
// self-checking bench for the serial target port
`timescale 1ns/10ps
module ltp_target_port_tb_top;
	import ltp_pkg::*;

	logic        clk          = 1'b0;
	logic        rst          = 1'b1;
	logic        hold         = 1'b0;
	logic        reg_wr_ready = 1'b0;
	logic [1:0]  lo_sel       = 2'h0;
	logic [1:0]  hi_sel       = 2'h0;
	logic        scl, sda, scl_m, sda_m, scl_oe, sda_oe, hung, strap_lo, strap_hi;
	logic        scl_o, sda_o;
	logic        reg_wr_valid;
	logic [7:0]  reg_addr, reg_wr_addr, reg_wr_data, rd_data;
	logic [7:0]  mem [256];
	logic [7:0]  exp_mem [256];
	logic [15:0] wq [$];
	logic [15:0] wexp;
	logic [6:0]  own;
	int          mismatches = 0;
	int          tests_run  = 0;

	// ------------------------------------------------------------
	// clock, wires, straps
	// ------------------------------------------------------------
	always #10 clk = ~clk;
	assign scl = scl_m & (scl_oe ? scl_o : 1'b1);
	assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
	assign strap_lo = (lo_sel == 2'h0) ? 1'b0 : (lo_sel == 2'h1) ? scl : (lo_sel == 2'h2) ? sda : 1'b1;
	assign strap_hi = (hi_sel == 2'h0) ? 1'b0 : (hi_sel == 2'h1) ? scl : (hi_sel == 2'h2) ? sda : 1'b1;
	assign rd_data = mem[reg_addr];

	ltp_target_port #(.FIFO_DEPTH_P(4)) DUT (
		.clk             (clk),
		.rst             (rst),
		.scl_i           (scl),
		.scl_o           (scl_o),
		.scl_oe          (scl_oe),
		.sda_i           (sda),
		.sda_o           (sda_o),
		.sda_oe          (sda_oe),
		.addr_strap_low  (strap_lo),
		.addr_strap_high (strap_hi),
		.reg_addr        (reg_addr),
		.reg_rd_data     (rd_data),
		.reg_wr_addr     (reg_wr_addr),
		.reg_wr_data     (reg_wr_data),
		.reg_wr_valid    (reg_wr_valid),
		.reg_wr_ready    (reg_wr_ready)
	);

	ltp_i2c_ctrl_model ctl (
		.clk   (clk),
		.scl   (scl),
		.sda   (sda),
		.scl_m (scl_m),
		.sda_m (sda_m),
		.hung  (hung)
	);

	// ------------------------------------------------------------
	// checking and verdict
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// register map side: random stalls, writes matched against notes
	always @(posedge clk) begin
		reg_wr_ready <= !hold && ($urandom_range(3) != 0);
		if (reg_wr_valid === 1'b1 && reg_wr_ready === 1'b1) begin
			if (wq.size() == 0) begin
				mismatches++;
				$display("BAD %0t unexpected register write", $time);
			end else begin
				wexp = wq.pop_front();
				check({reg_wr_addr, reg_wr_data}, wexp);
				mem[reg_wr_addr] <= reg_wr_data;
			end
		end
	end

	// ------------------------------------------------------------
	// transfers
	// ------------------------------------------------------------
	task automatic wr_burst(input logic [7:0] ptr, input int n);
		logic       a;
		logic [7:0] d;
		logic [7:0] p;
		ctl.start();
		ctl.wbyte({own, 1'b0}, a);
		check(16'(a), 16'h0001);
		ctl.wbyte(ptr, a);
		check(16'(a), 16'h0001);
		for (int k = 0; k < n; k++) begin
			p = ptr + 8'(k);
			d = 8'($urandom);
			exp_mem[p] = d;
			wq.push_back({p, d});
			ctl.wbyte(d, a);
			check(16'(a), 16'h0001);
		end
		ctl.stop();
	endtask : wr_burst

	task automatic rd_burst(input logic [7:0] ptr, input int n);
		logic       a;
		logic [7:0] d;
		logic [7:0] p;
		ctl.start();
		ctl.wbyte({own, 1'b0}, a);
		ctl.wbyte(ptr, a);
		ctl.start();
		ctl.wbyte({own, 1'b1}, a);
		check(16'(a), 16'h0001);
		for (int k = 0; k < n; k++) begin
			p = ptr + 8'(k);
			ctl.rbyte(k < n - 1, d);
			check({8'h00, d}, {8'h00, exp_mem[p]});
		end
		ctl.stop();
	endtask : rd_burst

	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		$display("BAD %0t run limit reached", $time);
		wrap_up();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic       a;
		logic [7:0] d;
		logic [6:0] ad;
		int         n;
		void'($urandom(53985));
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($urandom);
			exp_mem[i] = mem[i];
		end
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		// every strap pairing, then a one-bit-off address
		for (int c = 0; c < 16; c++) begin
			lo_sel <= c[1:0];
			hi_sel <= c[3:2];
			ad = {ADDR_FIXED, c[3:0]};
			ctl.start();
			ctl.wbyte({ad, 1'b0}, a);
			check(16'(a), 16'h0001);
			ctl.stop();
			ctl.start();
			ctl.wbyte({ad ^ (7'h01 << (c % 7)), 1'b0}, a);
			check(16'(a), 16'h0000);
			ctl.wbyte(8'($urandom), a);
			check(16'(a), 16'h0000);
			ctl.stop();
		end
		own = {ADDR_FIXED, 2'h2, 2'h1};
		lo_sel <= 2'h1;
		hi_sel <= 2'h2;
		// long wrapping burst while the map stalls, filling the buffer
		hold <= 1'b1;
		fork
			wr_burst(8'hFD, 7);
			begin
				repeat (1500) @(posedge clk);
				hold <= 1'b0;
			end
		join
		rd_burst(8'hFE, 4);
		wr_burst(8'h40, 1);
		rd_burst(8'h3F, 3);
		rd_burst(8'h80, 2);
		// read with a foreign address: bus stays released
		ctl.start();
		ctl.wbyte({own ^ 7'h20, 1'b1}, a);
		check(16'(a), 16'h0000);
		ctl.rbyte(1'b0, d);
		check({8'h00, d}, 16'h00FF);
		ctl.stop();
		n = 0;
		while (wq.size() != 0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		check(16'(wq.size()), 16'h0000);
		check(16'(hung), 16'h0000);
		check({14'h0000, scl_o, sda_o}, 16'h0000);
		wrap_up();
	end
endmodule : ltp_target_port_tb_top
